//--- design/bsr_tap_top.v
// Purpose : Boundary-scan test port with instruction, bypass, ID and scan registers
// Assumes : Test pins are sampled by CLK_SYS_I, which runs far above the test clock
// Notes   : Test-clock edges are found after a two-stage synchroniser
`timescale 1ns/100ps
`default_nettype none
`include "bsr_defs.vh"

module bsr_tap_top #(
  parameter NUM_IN  = 4,            // Observe-only input pins
  parameter NUM_OUT = 4,            // Output-only pins
  parameter NUM_BID = 4,            // Bidirectional pins
  parameter [`BSR_ID_W-1:0] DEV_ID = 32'h00000001 // Arbitrary value, LSB must be 1
) (
  input  wire               CLK_SYS_I,
  input  wire               SYS_RST_I,
  input  wire               CE_I,
  input  wire               TCK_I,
  input  wire               TMS_I,
  input  wire               TDI_I,
  input  wire               TRST_N_I,
  output reg                TDO_O,
  output reg                TDO_OE_N_O,
  input  wire [NUM_IN-1:0]  IN_PAD_I,
  input  wire [NUM_OUT-1:0] CORE_OUT_I,
  input  wire [NUM_OUT-1:0] CORE_OUT_OE_I,
  output reg  [NUM_OUT-1:0] OUT_PAD_O,
  output reg  [NUM_OUT-1:0] OUT_PAD_OE_N_O,
  input  wire [NUM_BID-1:0] BID_PAD_I,
  input  wire [NUM_BID-1:0] CORE_BID_OUT_I,
  input  wire [NUM_BID-1:0] CORE_BID_OE_I,
  output reg  [NUM_BID-1:0] BID_PAD_O,
  output reg  [NUM_BID-1:0] BID_PAD_OE_N_O
);

  // Chain layout, index 0 sits next to TDO
  localparam O_DAT = NUM_IN;
  localparam O_ENA = NUM_IN + NUM_OUT;
  localparam B_ENA = NUM_IN + 2 * NUM_OUT;
  localparam B_CAP = NUM_IN + 2 * NUM_OUT + NUM_BID;
  localparam CHAIN = NUM_IN + 2 * NUM_OUT + 2 * NUM_BID;

  // ****************************************************************
  // Pin synchronisers (first stage read only by the second)
  // ****************************************************************
  reg [3:0]         pin_s1_ff;     // TCK, TMS, TDI, TRST_N first stage
  reg [3:0]         pin_s2_ff;     // Second stage, safe to use
  reg               tck_d_ff;      // Delayed TCK for edge finding
  reg [NUM_IN-1:0]  in_s1_ff;      // Input pad first stage
  reg [NUM_IN-1:0]  in_s2_ff;      // Input pad usable value
  reg [NUM_BID-1:0] bid_s1_ff;     // Bidir pad first stage
  reg [NUM_BID-1:0] bid_s2_ff;     // Bidir pad usable value

  always @(posedge CLK_SYS_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      pin_s1_ff <= 4'h1;
      pin_s2_ff <= 4'h1;
      tck_d_ff  <= 1'h0;
      in_s1_ff  <= {NUM_IN{1'b0}};
      in_s2_ff  <= {NUM_IN{1'b0}};
      bid_s1_ff <= {NUM_BID{1'b0}};
      bid_s2_ff <= {NUM_BID{1'b0}};
    end
    else if (CE_I)
    begin
      pin_s1_ff <= {TCK_I, TMS_I, TDI_I, TRST_N_I};
      pin_s2_ff <= pin_s1_ff;
      tck_d_ff  <= pin_s2_ff[3];
      in_s1_ff  <= IN_PAD_I;
      in_s2_ff  <= in_s1_ff;
      bid_s1_ff <= BID_PAD_I;
      bid_s2_ff <= bid_s1_ff;
    end
  end

  wire tck_rise = pin_s2_ff[3] & ~tck_d_ff;  // One-cycle rising strobe
  wire tck_fall = ~pin_s2_ff[3] & tck_d_ff;  // One-cycle falling strobe
  wire tms_s    = pin_s2_ff[2];
  wire tdi_s    = pin_s2_ff[1];
  wire trst_n_s = pin_s2_ff[0];

  // ****************************************************************
  // Controller state machine
  // ****************************************************************
  reg [`BSR_ST_W-1:0] st_ff;       // Current controller state
  reg [`BSR_ST_W-1:0] nxt_st;      // Next state on rising edge

  always @*
  begin
    case (st_ff)
      `BSR_ST_RESET:    nxt_st = tms_s ? `BSR_ST_RESET   : `BSR_ST_IDLE;
      `BSR_ST_IDLE:     nxt_st = tms_s ? `BSR_ST_SEL_DR  : `BSR_ST_IDLE;
      `BSR_ST_SEL_DR:   nxt_st = tms_s ? `BSR_ST_SEL_IR  : `BSR_ST_CAP_DR;
      `BSR_ST_CAP_DR:   nxt_st = tms_s ? `BSR_ST_EXIT1_DR : `BSR_ST_SHIFT_DR;
      `BSR_ST_SHIFT_DR: nxt_st = tms_s ? `BSR_ST_EXIT1_DR : `BSR_ST_SHIFT_DR;
      `BSR_ST_EXIT1_DR: nxt_st = tms_s ? `BSR_ST_UPD_DR  : `BSR_ST_PAUSE_DR;
      `BSR_ST_PAUSE_DR: nxt_st = tms_s ? `BSR_ST_EXIT2_DR : `BSR_ST_PAUSE_DR;
      `BSR_ST_EXIT2_DR: nxt_st = tms_s ? `BSR_ST_UPD_DR  : `BSR_ST_SHIFT_DR;
      `BSR_ST_UPD_DR:   nxt_st = tms_s ? `BSR_ST_SEL_DR  : `BSR_ST_IDLE;
      `BSR_ST_SEL_IR:   nxt_st = tms_s ? `BSR_ST_RESET   : `BSR_ST_CAP_IR;
      `BSR_ST_CAP_IR:   nxt_st = tms_s ? `BSR_ST_EXIT1_IR : `BSR_ST_SHIFT_IR;
      `BSR_ST_SHIFT_IR: nxt_st = tms_s ? `BSR_ST_EXIT1_IR : `BSR_ST_SHIFT_IR;
      `BSR_ST_EXIT1_IR: nxt_st = tms_s ? `BSR_ST_UPD_IR  : `BSR_ST_PAUSE_IR;
      `BSR_ST_PAUSE_IR: nxt_st = tms_s ? `BSR_ST_EXIT2_IR : `BSR_ST_PAUSE_IR;
      `BSR_ST_EXIT2_IR: nxt_st = tms_s ? `BSR_ST_UPD_IR  : `BSR_ST_SHIFT_IR;
      `BSR_ST_UPD_IR:   nxt_st = tms_s ? `BSR_ST_SEL_DR  : `BSR_ST_IDLE;
      default:          nxt_st = `BSR_ST_RESET;
    endcase
  end

  // Five TMS ones reach reset from any state through the table above
  always @(posedge CLK_SYS_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
      st_ff <= `BSR_ST_RESET;
    else if (CE_I)
    begin
      if (!trst_n_s)
        st_ff <= `BSR_ST_RESET;
      else if (tck_rise)
        st_ff <= nxt_st;
    end
  end

  wire in_shdr = (st_ff == `BSR_ST_SHIFT_DR);
  wire in_shir = (st_ff == `BSR_ST_SHIFT_IR);
  wire cap_dr  = tck_rise & (st_ff == `BSR_ST_CAP_DR);
  wire sh_dr   = tck_rise & in_shdr;

  // ****************************************************************
  // Instruction register: shift stage and current instruction
  // ****************************************************************
  reg [`BSR_IR_W-1:0] ir_sr_ff;    // Shift stage
  reg [`BSR_IR_W-1:0] ir_cur_ff;   // Instruction in effect

  always @(posedge CLK_SYS_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      ir_sr_ff  <= `BSR_OP_IDCODE;
      ir_cur_ff <= `BSR_OP_IDCODE;
    end
    else if (CE_I)
    begin
      if (!trst_n_s || st_ff == `BSR_ST_RESET)
        ir_cur_ff <= `BSR_OP_IDCODE;
      else if (tck_fall && st_ff == `BSR_ST_UPD_IR)
        ir_cur_ff <= ir_sr_ff;
      if (tck_rise && st_ff == `BSR_ST_CAP_IR)
        ir_sr_ff <= `BSR_IR_CAPTURE_PAT;
      else if (tck_rise && in_shir)
        ir_sr_ff <= {tdi_s, ir_sr_ff[`BSR_IR_W-1:1]};
    end
  end

  // Opcode decode; reserved codes fall back to the bypass path
  wire op_extest = (ir_cur_ff == `BSR_OP_EXTEST);
  wire op_sample = (ir_cur_ff == `BSR_OP_SAMPLE);
  wire op_id     = (ir_cur_ff == `BSR_OP_IDCODE);
  wire op_float  = (ir_cur_ff == `BSR_OP_ALL_FLOAT);
  wire op_clamp  = (ir_cur_ff == `BSR_OP_CLAMP);
  wire sel_bsr   = op_extest | op_sample;
  wire pins_held = op_extest | op_clamp;

  // ****************************************************************
  // Bypass and device ID registers
  // ****************************************************************
  reg                 byp_ff;      // Single-bit bypass
  reg [`BSR_ID_W-1:0] id_ff;       // Identification shift register

  always @(posedge CLK_SYS_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      byp_ff <= `BSR_RST_BYPASS;
      id_ff  <= {`BSR_ID_W{1'b0}};
    end
    else if (CE_I)
    begin
      // The ID register moves only when selected; bypass captures on every capture-DR
      if (cap_dr)
        byp_ff <= `BSR_BYPASS_CAPTURE;
      else if (sh_dr && !sel_bsr && !op_id)
        byp_ff <= tdi_s;
      if (cap_dr && op_id)
        id_ff <= DEV_ID;
      else if (sh_dr && op_id)
        id_ff <= {tdi_s, id_ff[`BSR_ID_W-1:1]};
    end
  end

  // ****************************************************************
  // Boundary-scan chain
  // ****************************************************************
  wire [CHAIN-1:0]   cap_vec;      // Parallel capture values
  wire [CHAIN-1:0]   so_vec;       // Shift outputs
  wire [CHAIN-1:0]   uo_vec;       // Update latch outputs
  wire [NUM_BID-1:0] bid_cap;      // Muxed bidir capture source
  wire               upd_dr = tck_fall & (st_ff == `BSR_ST_UPD_DR) & sel_bsr;
  genvar k;

  // Bidir capture mux, steered by the core enable unless extest
  generate
    for (k = 0; k < NUM_BID; k = k + 1)
    begin : g_bmux
      assign bid_cap[k] = (CORE_BID_OE_I[k] & ~op_extest) ? CORE_BID_OUT_I[k]
                                                          : bid_s2_ff[k];
    end
  endgenerate

  // Observe cells first, then output/enable control cells, then bidir pairs
  assign cap_vec = {bid_cap, CORE_BID_OE_I, CORE_OUT_OE_I, CORE_OUT_I, in_s2_ff};

  generate
    for (k = 0; k < CHAIN; k = k + 1)
    begin : g_cell
      bsr_scan_cell #(
        .HAS_UPD ((k >= NUM_IN) ? 1 : 0)
      ) u_cell (
        .clk_i   (CLK_SYS_I),
        .rst_i   (SYS_RST_I),
        .ce_i    (CE_I),
        .cap_i   (cap_dr & sel_bsr),
        .shift_i (sh_dr & sel_bsr),
        .upd_i   (upd_dr),
        .si_i    ((k == CHAIN - 1) ? tdi_s : so_vec[(k + 1) % CHAIN]),
        .pi_i    (cap_vec[k]),
        .so_o    (so_vec[k]),
        .uo_o    (uo_vec[k])
      );
    end
  endgenerate

  // ****************************************************************
  // Pad drivers: core values, held latch values, or all floating
  // ****************************************************************
  always @(posedge CLK_SYS_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      OUT_PAD_O      <= {NUM_OUT{1'b0}};
      OUT_PAD_OE_N_O <= {NUM_OUT{1'b1}};
      BID_PAD_O      <= {NUM_BID{1'b0}};
      BID_PAD_OE_N_O <= {NUM_BID{1'b1}};
    end
    else if (CE_I)
    begin
      if (op_float)
      begin
        OUT_PAD_O      <= CORE_OUT_I;
        OUT_PAD_OE_N_O <= {NUM_OUT{1'b1}};
        BID_PAD_O      <= CORE_BID_OUT_I;
        BID_PAD_OE_N_O <= {NUM_BID{1'b1}};
      end
      else if (pins_held)
      begin
        // Latch contents reach the pins as soon as the instruction lands
        OUT_PAD_O      <= uo_vec[O_ENA-1:O_DAT];
        OUT_PAD_OE_N_O <= ~uo_vec[B_ENA-1:O_ENA];
        BID_PAD_O      <= uo_vec[CHAIN-1:B_CAP];
        BID_PAD_OE_N_O <= ~uo_vec[B_CAP-1:B_ENA];
      end
      else
      begin
        OUT_PAD_O      <= CORE_OUT_I;
        OUT_PAD_OE_N_O <= ~CORE_OUT_OE_I;
        BID_PAD_O      <= CORE_BID_OUT_I;
        BID_PAD_OE_N_O <= ~CORE_BID_OE_I;
      end
    end
  end

  // ****************************************************************
  // Serial output: selected register LSB, moved on the falling edge
  // ****************************************************************
  reg nxt_tdo;

  always @*
  begin
    if (in_shir)
      nxt_tdo = ir_sr_ff[0];
    else if (sel_bsr)
      nxt_tdo = so_vec[0];
    else if (op_id)
      nxt_tdo = id_ff[0];
    else
      nxt_tdo = byp_ff;
  end

  always @(posedge CLK_SYS_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      TDO_O      <= 1'h0;
      TDO_OE_N_O <= 1'h1;
    end
    else if (CE_I && tck_fall)
    begin
      TDO_O      <= nxt_tdo;
      TDO_OE_N_O <= ~(in_shdr | in_shir);
    end
  end

endmodule

`default_nettype wire

//--- design/bsr_defs.vh
// Purpose : Shared constants of the boundary-scan test port
// Assumes : Included by bare name from the design files
// Notes   : Definitions only; guarded against double inclusion
`ifndef BSR_DEFS_VH
`define BSR_DEFS_VH

// ****************************************************************
// Instruction register
// ****************************************************************
`define BSR_IR_W            6
`define BSR_OP_EXTEST       6'h00
`define BSR_OP_SAMPLE       6'h01
`define BSR_OP_IDCODE       6'h02
`define BSR_OP_ALL_FLOAT    6'h03
`define BSR_OP_CLAMP        6'h3e
`define BSR_OP_BYPASS       6'h3f
`define BSR_IR_CAPTURE_PAT  6'h2d

// ****************************************************************
// Controller state codes
// ****************************************************************
`define BSR_ST_W            4
`define BSR_ST_RESET        4'h0
`define BSR_ST_IDLE         4'h1
`define BSR_ST_SEL_DR       4'h2
`define BSR_ST_CAP_DR       4'h3
`define BSR_ST_SHIFT_DR     4'h4
`define BSR_ST_EXIT1_DR     4'h5
`define BSR_ST_PAUSE_DR     4'h6
`define BSR_ST_EXIT2_DR     4'h7
`define BSR_ST_UPD_DR       4'h8
`define BSR_ST_SEL_IR       4'h9
`define BSR_ST_CAP_IR       4'ha
`define BSR_ST_SHIFT_IR     4'hb
`define BSR_ST_EXIT1_IR     4'hc
`define BSR_ST_PAUSE_IR     4'hd
`define BSR_ST_EXIT2_IR     4'he
`define BSR_ST_UPD_IR       4'hf

// ****************************************************************
// Reset and capture values and data register widths
// ****************************************************************
`define BSR_ID_W            32
`define BSR_RST_BYPASS      1'h0
`define BSR_BYPASS_CAPTURE  1'h0

`endif

//--- design/bsr_scan_cell.v
// Purpose : One boundary-scan cell: capture/shift stage plus optional update latch
// Assumes : Strobes are one system-clock pulses derived from test-clock edges
// Notes   : Observe-only cells are built with HAS_UPD = 0
`timescale 1ns/100ps
`default_nettype none

module bsr_scan_cell #(
  parameter HAS_UPD = 1
) (
  input  wire clk_i,
  input  wire rst_i,
  input  wire ce_i,
  input  wire cap_i,
  input  wire shift_i,
  input  wire upd_i,
  input  wire si_i,
  input  wire pi_i,
  output wire so_o,
  output wire uo_o
);

  reg sr_ff;  // Capture/shift stage
  reg up_ff;  // Update latch, falls-edge loaded

  // ****************************************************************
  // Capture and shift on the rising test-clock strobe
  // ****************************************************************
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      sr_ff <= 1'h0;
    else if (ce_i)
    begin
      if (cap_i)
        sr_ff <= pi_i;
      else if (shift_i)
        sr_ff <= si_i;
    end
  end

  // ****************************************************************
  // Update stage only where the cell may drive something
  // ****************************************************************
  generate
    if (HAS_UPD != 0)
    begin : g_upd
      // Loaded on the falling strobe so skew cannot corrupt captured data
      always @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
          up_ff <= 1'h0;
        else if (ce_i && upd_i)
          up_ff <= sr_ff;
      end
    end
    else
    begin : g_obs
      // Sample-only: nothing can reach the pin or the core, latch stays zero
      always @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
          up_ff <= 1'h0;
        else
          up_ff <= 1'h0;
      end
    end
  endgenerate

  assign so_o = sr_ff;
  assign uo_o = up_ff;

endmodule

`default_nettype wire

//--- test/bsr_tap_top_sva.sv
// Purpose : Pin-level checks of the boundary-scan test port
// Assumes : Test clock is far slower than CLK_SYS_I, one domain
// Notes   : Bound to the top module after the module body
`timescale 1ns/100ps
`default_nettype none

module bsr_tap_top_sva #(
  parameter NUM_OUT = 4,
  parameter NUM_BID = 4
) (
  input wire logic               CLK_SYS_I,
  input wire logic               SYS_RST_I,
  input wire logic               CE_I,
  input wire logic               TCK_I,
  input wire logic               TMS_I,
  input wire logic               TDO_O,
  input wire logic               TDO_OE_N_O,
  input wire logic [NUM_OUT-1:0] CORE_OUT_I,
  input wire logic [NUM_OUT-1:0] CORE_OUT_OE_I,
  input wire logic [NUM_OUT-1:0] OUT_PAD_O,
  input wire logic [NUM_OUT-1:0] OUT_PAD_OE_N_O,
  input wire logic [NUM_BID-1:0] CORE_BID_OE_I,
  input wire logic [NUM_BID-1:0] BID_PAD_OE_N_O
);
  // ****************************************************************
  // Mode select as seen at the last test-clock rise
  // ****************************************************************
  logic tck_prev_ff;  // Test clock one edge ago
  logic tms_rise_ff;  // Mode select taken at the last rise

  // Raw pin is good enough: mode select is held across each rise
  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I)
  begin
    if (SYS_RST_I)
    begin
      tck_prev_ff <= 1'b0;
      tms_rise_ff <= 1'b1;
    end
    else
    begin
      tck_prev_ff <= TCK_I;
      if (TCK_I && !tck_prev_ff)
        tms_rise_ff <= TMS_I;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);

  a_tdo_on_fall: assert property ($changed(TDO_O) |-> !$past(TCK_I) && !$past(TCK_I, 3))
    else $error("serial out moved while test clock high");
  a_oe_on_fall: assert property ($changed(TDO_OE_N_O) |-> !$past(TCK_I) && !$past(TCK_I, 3))
    else $error("serial out enable moved while test clock high");
  a_oe_needs_shift: assert property ($fell(TDO_OE_N_O) |-> !tms_rise_ff)
    else $error("serial out enabled without a shift entry");
  a_oe_exit_shift: assert property (($rose(TCK_I) && TMS_I && !TDO_OE_N_O) |-> ##[1:24] TDO_OE_N_O)
    else $error("serial out still enabled after leaving shift");
  a_pad_data_cause: assert property ($changed(OUT_PAD_O) |->
    ($past(CORE_OUT_I) != $past(CORE_OUT_I, 2)) || (!$past(TCK_I) && !$past(TCK_I, 3)))
    else $error("output pad changed without a cause");
  a_pad_oe_cause: assert property ($changed(OUT_PAD_OE_N_O) |->
    ($past(CORE_OUT_OE_I) != $past(CORE_OUT_OE_I, 2)) || (!$past(TCK_I) && !$past(TCK_I, 3)))
    else $error("output enable changed without a cause");
  a_bid_oe_cause: assert property ($changed(BID_PAD_OE_N_O) |->
    ($past(CORE_BID_OE_I) != $past(CORE_BID_OE_I, 2)) || (!$past(TCK_I) && !$past(TCK_I, 3)))
    else $error("bidir enable changed without a cause");
  a_freeze_hold: assert property (!$past(CE_I) |-> $stable(OUT_PAD_O) && $stable(TDO_O))
    else $error("outputs moved while clock enable low");
endmodule

bind bsr_tap_top bsr_tap_top_sva #(.NUM_OUT(NUM_OUT), .NUM_BID(NUM_BID)) chk_u (
  .CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .CE_I(CE_I), .TCK_I(TCK_I), .TMS_I(TMS_I),
  .TDO_O(TDO_O), .TDO_OE_N_O(TDO_OE_N_O), .CORE_OUT_I(CORE_OUT_I), .CORE_OUT_OE_I(CORE_OUT_OE_I),
  .OUT_PAD_O(OUT_PAD_O), .OUT_PAD_OE_N_O(OUT_PAD_OE_N_O), .CORE_BID_OE_I(CORE_BID_OE_I),
  .BID_PAD_OE_N_O(BID_PAD_OE_N_O)
);
`default_nettype wire

//--- test/bsr_jtag_ctl.sv
// Purpose : Board-level test controller driving the test port pins
// Assumes : Calls start just after a system clock edge
// Notes   : Test clock stands low between frames
`timescale 1ns/100ps
`default_nettype none

module bsr_jtag_ctl (
  input  wire logic tdo_i,
  input  wire logic tdo_oe_n_i,
  output var  logic tck_o,
  output var  logic tms_o,
  output var  logic tdi_o,
  output var  logic trst_n_o
);
  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    trst_n_o = 1'b1;
  end

  // One test-clock cycle; serial out is read just before the rise
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #80;
    tdo = tdo_oe_n_i ? ~tdo_i : tdo_i;  // A floating line reads as junk
    tck_o = 1'b1;
    #80;
    tck_o = 1'b0;
  endtask

  // Five ones reach test-logic-reset from anywhere
  task automatic tap_reset;
    logic b;
    repeat (5) tick(1'b1, tdi_o, b);
  endtask

  // Test reset pin pulse, long enough for the pin synchroniser
  task automatic trst_pulse;
    trst_n_o = 1'b0;
    #80;
    trst_n_o = 1'b1;
    #80;
  endtask

  // Full scan from idle or update; LSB first; upd low stops in exit1
  task automatic scan(input logic is_ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, input logic upd);
    logic b;
    dout = '0;
    tick(1'b0, tdi_o, b);
    tick(1'b1, tdi_o, b);
    if (is_ir)
      tick(1'b1, tdi_o, b);
    tick(1'b0, tdi_o, b);
    tick(1'b0, tdi_o, b);
    for (int i = 0; i < n; i++)
    begin
      tick(i == n - 1, din[i], b);
      dout[i] = b;
    end
    if (upd)
      tick(1'b1, ~din[n-1], b);
    tdi_o = ~din[n-1];
  endtask
endmodule
`default_nettype wire

//--- test/bsr_tap_top_test.sv
// Purpose : Self-checking bench of the boundary-scan test port
// Assumes : Default pin counts of four per kind
// Notes   : Chain is inputs, out data, out enables, bidir enables, bidir capture
`timescale 1ns/100ps
`default_nettype none
`include "bsr_defs.vh"

module bsr_tap_top_test;
  localparam logic [31:0] DEV_ID  = 32'h13579bdf;  // Arbitrary value, LSB 1
  localparam logic [31:0] PRELOAD = 32'h09350;     // Safe latch values
  logic       clk, rst, ce, tck, tms, tdi, trst_n, tdo, tdo_oe_n;
  logic [3:0] in_pad, core_out, core_oe, out_pad, out_oe_n;
  logic [3:0] bid_pad, core_bid_out, core_bid_oe, bid_pad_o, bid_oe_n;
  int         mismatches = 0;
  int         checks_done = 0;

  bsr_tap_top #(.DEV_ID(DEV_ID)) dut_u (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .CE_I(ce), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi),
    .TRST_N_I(trst_n), .TDO_O(tdo), .TDO_OE_N_O(tdo_oe_n), .IN_PAD_I(in_pad),
    .CORE_OUT_I(core_out), .CORE_OUT_OE_I(core_oe), .OUT_PAD_O(out_pad), .OUT_PAD_OE_N_O(out_oe_n),
    .BID_PAD_I(bid_pad), .CORE_BID_OUT_I(core_bid_out), .CORE_BID_OE_I(core_bid_oe),
    .BID_PAD_O(bid_pad_o), .BID_PAD_OE_N_O(bid_oe_n));

  bsr_jtag_ctl ctl_u (.tdo_i(tdo), .tdo_oe_n_i(tdo_oe_n), .tck_o(tck), .tms_o(tms), .tdi_o(tdi),
    .trst_n_o(trst_n));

  always #4 clk = ~clk;

  task automatic stop_test;
    if (mismatches == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Stimulus lands one step after a clock edge
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Instruction load; eight clocks let the new mode reach the pads
  task automatic load_ir(input logic [5:0] op);
    logic [31:0] cap;
    ctl_u.scan(1'b1, 6, {26'h0, op}, cap, 1'b1);
    check("ir capture", {26'h0, `BSR_IR_CAPTURE_PAT}, cap);
    wait_clk(8);
  endtask

  task automatic dr_scan(input int n, input logic [31:0] din, output logic [31:0] dout);
    ctl_u.scan(1'b0, n, din, dout, 1'b1);
    wait_clk(8);
  endtask

  task automatic t_idcode;
    logic [31:0] d;
    check("tdo enable idle", 32'h1, {31'h0, tdo_oe_n});
    dr_scan(32, 32'h0, d);
    check("device id", DEV_ID, d);
  endtask

  task automatic t_sample;
    logic [31:0] d;
    load_ir(`BSR_OP_SAMPLE);
    dr_scan(20, PRELOAD, d);
    check("sample chain", 32'h63c69, d);
    check("pads in sample", {24'h0, ~core_oe, core_out}, {24'h0, out_oe_n, out_pad});
  endtask

  task automatic t_extest;
    logic [31:0] d;
    logic        b;
    ctl_u.scan(1'b1, 6, {26'h0, `BSR_OP_EXTEST}, d, 1'b0);
    wait_clk(8);
    check("pads before update", {28'h0, core_out}, {28'h0, out_pad});
    ctl_u.tick(1'b1, tdi, b);
    wait_clk(8);
    check("extest pads", 32'h6c5, {20'h0, bid_oe_n, out_oe_n, out_pad});
    core_out = 4'h3;
    dr_scan(20, PRELOAD, d);
    check("extest bidir capture", 32'h5, {28'h0, d[19:16]});
    check("extest inputs", 32'h9, {28'h0, d[3:0]});
    check("pads hold latches", 32'h5, {28'h0, out_pad});
  endtask

  task automatic t_modes;
    load_ir(`BSR_OP_CLAMP);
    check("clamp pads", 32'h5, {28'h0, out_pad});
    load_ir(`BSR_OP_ALL_FLOAT);
    check("float enables", 32'hff, {24'h0, bid_oe_n, out_oe_n});
  endtask

  task automatic t_bypass;
    logic [5:0]  ops [3] = '{`BSR_OP_BYPASS, `BSR_OP_CLAMP, 6'h15};
    logic [31:0] d;
    foreach (ops[i])
    begin
      load_ir(ops[i]);
      dr_scan(8, 32'ha5, d);
      check("bypass path", 32'h4a, {24'h0, d[7:0]});
    end
  endtask

  task automatic t_follow;
    core_out = 4'ha;
    core_bid_oe = 4'hc;
    wait_clk(3);
    check("pads follow core", 32'ha3a, {20'h0, bid_pad_o, bid_oe_n, out_pad});
    ce = 1'b0;
    core_out = 4'h6;
    wait_clk(4);
    check("pads frozen", 32'ha, {28'h0, out_pad});
    ce = 1'b1;
    wait_clk(3);
    check("pads resume", 32'h6, {28'h0, out_pad});
  endtask

  task automatic t_resets;
    load_ir(`BSR_OP_BYPASS);
    ctl_u.tap_reset();
    t_idcode();
    load_ir(`BSR_OP_BYPASS);
    ctl_u.trst_pulse();
    wait_clk(4);
    t_idcode();
  endtask

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    in_pad = 4'h9;
    core_out = 4'h6;
    core_oe = 4'hc;
    bid_pad = 4'h5;
    core_bid_out = 4'ha;
    core_bid_oe = 4'h3;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    wait_clk(4);
    t_idcode();
    t_sample();
    t_extest();
    t_modes();
    t_bypass();
    t_follow();
    t_resets();
    stop_test();
  end

  initial
  begin
    #400000;
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire
